// *** design/cpu_int_accept.v ***
// Interrupt acceptance sequencer with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "cpu_int_accept_map.vh"
module cpu_int_accept #(
   parameter AW = 24
) (
   input  wire          clk,
   input  wire          reset_n,
   input  wire          periph_req,
   output reg           req_clr_ff,
   output reg  [5:0]    req_clr_num_ff,
   output reg           mem_req_ff,
   output reg           mem_we_ff,
   output reg  [AW-1:0] mem_addr_ff,
   output reg  [31:0]   mem_wdata_ff,
   input  wire [31:0]   mem_rdata,
   input  wire          mem_ack,
   output reg           irq_ff,
   input  wire [7:0]    s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [7:0]    s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready
);
   // ==========================================
   // States
   localparam [7:0] ST_IDLE  = 8'h01;
   localparam [7:0] ST_INFO  = 8'h02;
   localparam [7:0] ST_SAVE  = 8'h04;
   localparam [7:0] ST_MASK  = 8'h08;
   localparam [7:0] ST_PUSHF = 8'h10;
   localparam [7:0] ST_PUSHP = 8'h20;
   localparam [7:0] ST_IPL   = 8'h40;
   localparam [7:0] ST_VEC   = 8'h80;

   reg  [7:0]    st_ff;
   reg  [7:0]    flg_ff;
   reg  [7:0]    tmp_flg_ff;
   reg  [AW-1:0] pc_ff;
   reg  [AW-1:0] isp_ff;
   reg  [AW-1:0] usp_ff;
   reg  [AW-1:0] vbase_ff;
   reg  [AW-1:0] fbase_ff;
   reg  [2:0]    ipl_ff;
   reg  [5:0]    num_ff;
   reg  [2:0]    lvl_ff;
   reg           is_trap_ff;
   reg           is_fix_ff;
   reg           skip_info_ff;
   reg           trap_pend_ff;
   reg  [5:0]    trap_num_ff;
   reg           trap_fix_ff;
   reg  [1:0]    istat_ff;
   reg  [1:0]    imask_ff;
   reg           aw_got_ff;
   reg           w_got_ff;
   reg  [7:0]    aw_addr_ff;
   reg  [31:0]   w_data_ff;
   reg  [3:0]    w_strb_ff;

   // ==========================================
   // Helpers
   function in_periph;
      input [5:0] n;
      begin
         in_periph = (n >= `NUM_PERIPH_FIRST) && (n <= `NUM_PERIPH_LAST);
      end
   endfunction

   // Saves go through the pointer the U flag selects; MASK clears U before PUSHF, so this is always the interrupt stack pointer.
   function [AW-1:0] active_sp;
      input [7:0]    f;
      input [AW-1:0] interrupt_stack_pointer;
      input [AW-1:0] user_stack_pointer;
      begin
         active_sp = f[`FLG_U] ? user_stack_pointer : interrupt_stack_pointer;
      end
   endfunction

   function [32:0] reg_read;
      input [7:0]   a;
      input [351:0] b;
      begin
         if (a == `RA_FLAG) begin
            reg_read = {1'b1, b[31:0]};
         end else if (a == `RA_PC) begin
            reg_read = {1'b1, b[63:32]};
         end else if (a == `RA_ISP) begin
            reg_read = {1'b1, b[95:64]};
         end else if (a == `RA_USP) begin
            reg_read = {1'b1, b[127:96]};
         end else if (a == `RA_IPL) begin
            reg_read = {1'b1, b[159:128]};
         end else if (a == `RA_VBASE) begin
            reg_read = {1'b1, b[191:160]};
         end else if (a == `RA_FBASE) begin
            reg_read = {1'b1, b[223:192]};
         end else if (a == `RA_TRAP) begin
            reg_read = {1'b1, b[255:224]};
         end else if (a == `RA_STATUS) begin
            reg_read = {1'b1, b[287:256]};
         end else if (a == `RA_ISTAT) begin
            reg_read = {1'b1, b[319:288]};
         end else if (a == `RA_IMASK) begin
            reg_read = {1'b1, b[351:320]};
         end else begin
            reg_read = {1'b0, 32'h00000000};
         end
      end
   endfunction

   function [31:0] merge;
      input [31:0] o;
      input [31:0] n;
      input [3:0]  s;
      begin
         merge = {s[3] ? n[31:24] : o[31:24], s[2] ? n[23:16] : o[23:16],
                  s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
      end
   endfunction

   // ==========================================
   // Bus read/write decode, events and sequencer addresses
   // Word k of the bank is the register at offset 4k. The decoder sees registers only
   // through this argument, so its results follow every register change, not just address changes.
   wire [351:0]  reg_bank = {30'h00000000, imask_ff, 30'h00000000, istat_ff,
                             14'h0000, ~st_ff[0], trap_pend_ff, 5'h00, lvl_ff, 2'b00, num_ff,
                             23'h000000, trap_fix_ff, 2'b00, trap_num_ff,
                             {(32-AW){1'b0}}, fbase_ff, {(32-AW){1'b0}}, vbase_ff,
                             29'h00000000, ipl_ff, {(32-AW){1'b0}}, usp_ff,
                             {(32-AW){1'b0}}, isp_ff, {(32-AW){1'b0}}, pc_ff, 24'h000000, flg_ff};
   wire [32:0]   wr_old = reg_read(aw_addr_ff, reg_bank);
   wire [31:0]   wv     = merge(wr_old[31:0], w_data_ff, w_strb_ff);
   wire          wr_go  = aw_got_ff && w_got_ff && !s_axi_bvalid;
   wire [32:0]   rd_val = reg_read(s_axi_araddr, reg_bank);
   wire          mem_done = mem_req_ff && mem_ack;
   wire [5:0]    info_num = mem_rdata[5:0];
   wire          ev_accept = (st_ff == ST_VEC) && mem_done;
   wire          ev_range = ((st_ff == ST_IDLE) && trap_pend_ff && !trap_fix_ff && in_periph(trap_num_ff)) ||
                            ((st_ff == ST_INFO) && mem_done && !is_trap_ff && !in_periph(info_num));
   wire [1:0]    ev_set = {ev_range, ev_accept};
   wire [1:0]    ev_clr = (wr_go && aw_addr_ff == `RA_ISTAT) ? wv[1:0] : 2'b00;
   wire [AW-1:0] sp_now = active_sp(flg_ff, isp_ff, usp_ff);
   wire [AW-1:0] vec_addr = is_fix_ff ? fbase_ff + {{(AW-6){1'b0}}, num_ff[3:0], 2'b00}
                                      : vbase_ff + {{(AW-8){1'b0}}, num_ff, 2'b00};

   // ==========================================
   // AXI4-Lite handshakes
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
         aw_got_ff     <= 1'b0;
         w_got_ff      <= 1'b0;
         aw_addr_ff    <= 8'h00;
         w_data_ff     <= 32'h00000000;
         w_strb_ff     <= 4'h0;
      end else begin
         s_axi_awready <= !aw_got_ff && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_got_ff && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff  <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff  <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_old[32] ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
         end
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val[31:0];
            s_axi_rresp  <= rd_val[32] ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================
   // Register file and acceptance sequencer
   // The sequencer shares this process with bus writes so that it wins over
   // software on any register it touches in the same cycle.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= ST_IDLE;
         flg_ff <= `RST_FLAG;
         tmp_flg_ff <= `RST_FLAG;
         pc_ff <= `RST_ADDR;
         isp_ff <= `RST_ADDR;
         usp_ff <= `RST_ADDR;
         vbase_ff <= `RST_ADDR;
         fbase_ff <= `RST_ADDR;
         ipl_ff <= `RST_IPL;
         num_ff <= 6'h00;
         lvl_ff <= 3'h0;
         is_trap_ff <= 1'b0;
         is_fix_ff <= 1'b0;
         skip_info_ff <= 1'b0;
         trap_pend_ff <= 1'b0;
         trap_num_ff <= 6'h00;
         trap_fix_ff <= 1'b0;
         istat_ff <= 2'b00;
         imask_ff <= 2'b00;
         irq_ff <= 1'b0;
         req_clr_ff <= 1'b0;
         req_clr_num_ff <= 6'h00;
         mem_req_ff <= 1'b0;
         mem_we_ff <= 1'b0;
         mem_addr_ff <= `RST_ADDR;
         mem_wdata_ff <= 32'h00000000;
      end else begin
         req_clr_ff <= 1'b0;
         istat_ff <= (istat_ff & ~ev_clr) | ev_set;
         irq_ff <= |(((istat_ff & ~ev_clr) | ev_set) & imask_ff);
         if (wr_go) begin
            if (aw_addr_ff == `RA_FLAG) begin
               flg_ff <= wv[7:0];
            end else if (aw_addr_ff == `RA_PC) begin
               pc_ff <= wv[AW-1:0];
            end else if (aw_addr_ff == `RA_ISP) begin
               isp_ff <= wv[AW-1:0];
            end else if (aw_addr_ff == `RA_USP) begin
               usp_ff <= wv[AW-1:0];
            end else if (aw_addr_ff == `RA_IPL) begin
               ipl_ff <= wv[2:0];
            end else if (aw_addr_ff == `RA_VBASE) begin
               vbase_ff <= wv[AW-1:0];
            end else if (aw_addr_ff == `RA_FBASE) begin
               fbase_ff <= wv[AW-1:0];
            end else if (aw_addr_ff == `RA_TRAP) begin
               trap_pend_ff <= 1'b1;
               trap_num_ff <= wv[5:0];
               trap_fix_ff <= wv[`TRAP_FIX_BIT];
            end else if (aw_addr_ff == `RA_IMASK) begin
               imask_ff <= wv[1:0];
            end
         end
         case (st_ff)
            ST_IDLE: begin
               if (trap_pend_ff) begin
                  // A trap written in this very cycle stays pending instead of being lost.
                  trap_pend_ff <= wr_go && (aw_addr_ff == `RA_TRAP);
                  num_ff <= trap_num_ff;
                  is_trap_ff <= 1'b1;
                  is_fix_ff <= trap_fix_ff;
                  skip_info_ff <= trap_fix_ff || (trap_num_ff > `NUM_INFO_LAST);
                  if (!trap_fix_ff && in_periph(trap_num_ff)) begin
                     st_ff <= ST_IDLE;
                  end else if (trap_fix_ff || (trap_num_ff > `NUM_INFO_LAST)) begin
                     st_ff <= ST_SAVE;
                  end else begin
                     st_ff <= ST_INFO;
                  end
               end else if (periph_req && flg_ff[`FLG_I]) begin
                  is_trap_ff <= 1'b0;
                  is_fix_ff <= 1'b0;
                  skip_info_ff <= 1'b0;
                  st_ff <= ST_INFO;
               end
            end
            ST_INFO: begin
               if (!mem_req_ff) begin
                  mem_req_ff <= 1'b1;
                  mem_we_ff <= 1'b0;
                  mem_addr_ff <= `INFO_ADDR;
               end else if (mem_ack) begin
                  mem_req_ff <= 1'b0;
                  lvl_ff <= mem_rdata[`INFO_LVL_LO+:3];
                  if (!is_trap_ff) begin
                     num_ff <= info_num;
                  end
                  req_clr_ff <= 1'b1;
                  req_clr_num_ff <= is_trap_ff ? num_ff : info_num;
                  st_ff <= ST_SAVE;
               end
            end
            ST_SAVE: begin
               tmp_flg_ff <= flg_ff;
               st_ff <= ST_MASK;
            end
            ST_MASK: begin
               flg_ff[`FLG_U] <= 1'b0;
               flg_ff[`FLG_I] <= 1'b0;
               flg_ff[`FLG_D] <= 1'b0;
               st_ff <= ST_PUSHF;
            end
            ST_PUSHF: begin
               if (!mem_req_ff) begin
                  mem_req_ff <= 1'b1;
                  mem_we_ff <= 1'b1;
                  mem_addr_ff <= sp_now - `STACK_WORD;
                  mem_wdata_ff <= {24'h000000, tmp_flg_ff};
               end else if (mem_ack) begin
                  mem_req_ff <= 1'b0;
                  st_ff <= ST_PUSHP;
               end
            end
            ST_PUSHP: begin
               if (!mem_req_ff) begin
                  mem_req_ff <= 1'b1;
                  mem_we_ff <= 1'b1;
                  mem_addr_ff <= sp_now - `STACK_FRAME;
                  mem_wdata_ff <= {{(32-AW){1'b0}}, pc_ff};
               end else if (mem_ack) begin
                  mem_req_ff <= 1'b0;
                  if (flg_ff[`FLG_U]) begin
                     usp_ff <= usp_ff - `STACK_FRAME;
                  end else begin
                     isp_ff <= isp_ff - `STACK_FRAME;
                  end
                  st_ff <= ST_IPL;
               end
            end
            ST_IPL: begin
               if (!skip_info_ff) begin
                  ipl_ff <= lvl_ff;
               end
               st_ff <= ST_VEC;
            end
            ST_VEC: begin
               if (!mem_req_ff) begin
                  mem_req_ff <= 1'b1;
                  mem_we_ff <= 1'b0;
                  mem_addr_ff <= vec_addr;
               end else if (mem_ack) begin
                  mem_req_ff <= 1'b0;
                  pc_ff <= mem_rdata[AW-1:0];
                  st_ff <= ST_IDLE;
               end
            end
            default: begin
               st_ff <= ST_IDLE;
            end
         endcase
         // Flag bits cleared in MASK must not be revived by a bus write mid-sequence.
         if (!st_ff[0] && !st_ff[1] && !st_ff[2] && wr_go && aw_addr_ff == `RA_FLAG) begin
            flg_ff <= wv[7:0] & ~((8'h01 << `FLG_I) | (8'h01 << `FLG_U) | (8'h01 << `FLG_D));
         end
      end
   end
endmodule

// *** design/cpu_int_accept_map.vh ***
// Register offsets, field positions, reset values and interrupt numbers of the acceptance unit.
`ifndef CPU_INT_ACCEPT_MAP_VH
`define CPU_INT_ACCEPT_MAP_VH
// ==========================================
// Register byte offsets
`define RA_FLAG      8'h00
`define RA_PC        8'h04
`define RA_ISP       8'h08
`define RA_USP       8'h0C
`define RA_IPL       8'h10
`define RA_VBASE     8'h14
`define RA_FBASE     8'h18
`define RA_TRAP      8'h1C
`define RA_STATUS    8'h20
`define RA_ISTAT     8'h24
`define RA_IMASK     8'h28
// ==========================================
// Flag register fields and reset values
`define FLG_U        3'd7
`define FLG_I        3'd6
`define FLG_D        3'd2
`define RST_FLAG     8'h00
`define RST_ADDR     24'h000000
`define RST_IPL      3'h0
// ==========================================
// Trap command and info word layout
`define TRAP_FIX_BIT 4'd8
`define INFO_ADDR    24'h000000
`define INFO_LVL_LO  4'd8
// ==========================================
// Interrupt numbers
`define NUM_PERIPH_FIRST 6'd8
`define NUM_PERIPH_LAST  6'd43
`define NUM_INFO_LAST    6'd31
`define NUM_TIMER_B5     6'd32
`define NUM_SER2_TX      6'd33
`define NUM_SER2_RX      6'd34
`define NUM_SER3_TX      6'd35
`define NUM_SER3_RX      6'd36
`define NUM_SER4_TX      6'd37
`define NUM_SER4_RX      6'd38
`define NUM_SER2_BUS     6'd39
`define NUM_SER3_BUS     6'd40
`define NUM_SER4_BUS     6'd41
`define NUM_ANALOG       6'd42
`define NUM_KEY_INPUT    6'd43
// ==========================================
// Fixed vector slots
`define FIX_UNDEF_INSTR  4'h0
`define FIX_OVERFLOW     4'h1
`define FIX_BREAK_INSTR  4'h2
`define FIX_ADDR_MATCH   4'h3
`define FIX_WATCHDOG     4'h5
`define FIX_NMI          4'h7
`define FIX_RESET        4'h8
// ==========================================
// Event bits of the interrupt status register, stack offsets and bus responses
`define EV_ACCEPT    1'd0
`define EV_RANGE     1'd1
`define STACK_FRAME  24'h000008
`define STACK_WORD   24'h000004
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10
`endif

// *** tb/far_side_model.sv ***
// Memory and peripheral request source facing the acceptance unit.
`timescale 1ns/1ps
module far_side_model #(
   parameter AW = 24
) (
   input wire          clk,
   input wire          reset_n,
   input wire          raise,
   input wire          slow,
   input wire          req_clr_ff,
   input wire          mem_req_ff,
   input wire          mem_we_ff,
   input wire [AW-1:0] mem_addr_ff,
   input wire [31:0]   mem_wdata_ff,
   output reg [31:0]   mem_rdata,
   output reg          mem_ack,
   output reg          periph_req
);
   reg [31:0] mem [0:1023];
   reg [1:0]  wait_ff;
   integer    clr_count;
   // ==========================================
   // Request stays up until cleared; read data toggles when no answer is due.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_ack    <= 1'b0;
         wait_ff    <= 2'h0;
         periph_req <= 1'b0;
         mem_rdata  <= 32'h0;
         clr_count  <= 0;
      end else begin
         if (req_clr_ff) begin
            periph_req <= 1'b0;
            clr_count  <= clr_count + 1;
         end else if (raise) begin
            periph_req <= 1'b1;
         end
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req_ff && !mem_ack) begin
            if (wait_ff == (slow ? 2'h3 : 2'h0)) begin
               mem_ack <= 1'b1;
               wait_ff <= 2'h0;
               if (mem_we_ff) mem[mem_addr_ff[11:2]] <= mem_wdata_ff;
               else mem_rdata <= mem[mem_addr_ff[11:2]];
            end else begin
               wait_ff <= wait_ff + 2'h1;
            end
         end
      end
   end
endmodule

// *** tb/int_accept_checker_assertions.sv ***
// Concurrent checks on the ports of the interrupt acceptance unit.
`timescale 1ns/1ps
module int_accept_checker #(
   parameter AW = 24
) (
   input wire          clk,
   input wire          reset_n,
   input wire          req_clr_ff,
   input wire          mem_req_ff,
   input wire          mem_we_ff,
   input wire [AW-1:0] mem_addr_ff,
   input wire [31:0]   mem_wdata_ff,
   input wire          mem_ack,
   input wire          s_axi_awvalid,
   input wire          s_axi_awready,
   input wire          s_axi_wvalid,
   input wire          s_axi_wready,
   input wire          s_axi_bvalid,
   input wire          s_axi_bready,
   input wire [1:0]    s_axi_bresp,
   input wire          s_axi_arvalid,
   input wire          s_axi_arready,
   input wire          s_axi_rvalid,
   input wire          s_axi_rready,
   input wire [31:0]   s_axi_rdata
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ==========================================
   // Acceptance sequence
   clr_single_a: assert property (req_clr_ff |=> !req_clr_ff [*8])
      else $error("request clear repeated inside one acceptance");
   info_first_a: assert property (req_clr_ff |->
      $past(mem_req_ff && mem_ack && !mem_we_ff && mem_addr_ff == 0)
      || $past(mem_req_ff && mem_ack && !mem_we_ff && mem_addr_ff == 0, 2))
      else $error("request cleared without a prior info read");
   push_next_a: assert property (req_clr_ff |-> ##[1:6] (mem_req_ff && mem_we_ff))
      else $error("no push after request clear");
   mem_hold_a: assert property (mem_req_ff && !mem_ack |=> mem_req_ff && $stable(mem_addr_ff)
      && $stable(mem_we_ff) && $stable(mem_wdata_ff))
      else $error("memory request changed before ack");
   mem_drop_a: assert property (mem_req_ff && mem_ack |=> !mem_req_ff)
      else $error("memory request not released after ack");
   word_align_a: assert property (mem_req_ff |-> mem_addr_ff[1:0] == 2'b00)
      else $error("memory address not word aligned");
   // ==========================================
   // Register bus
   b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped early");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
endmodule
bind cpu_int_accept int_accept_checker #(.AW(AW)) checker_i (.clk(clk), .reset_n(reset_n),
   .req_clr_ff(req_clr_ff), .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
   .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// *** tb/tb_cpu_int_accept.sv ***
// Self-checking bench for the interrupt acceptance unit.
`timescale 1ns/1ps
`include "cpu_int_accept_map.vh"
module tb_cpu_int_accept;
   reg         clk, reset_n, raise, slow;
   reg  [7:0]  awaddr, araddr;
   reg  [31:0] wdata, d;
   reg         awvalid, wvalid, bready, arvalid, rready;
   reg  [1:0]  r;
   wire        awready, wready, bvalid, arready, rvalid, periph_req, req_clr_ff;
   wire        mem_req_ff, mem_we_ff, mem_ack, irq_ff;
   wire [1:0]  bresp, rresp;
   wire [5:0]  req_clr_num_ff;
   wire [23:0] mem_addr_ff;
   wire [31:0] rdata, mem_wdata_ff, mem_rdata;
   integer     fails, check_count, cyc, s;
   cpu_int_accept cpu_int_accept_i (.clk(clk), .reset_n(reset_n), .periph_req(periph_req),
      .req_clr_ff(req_clr_ff), .req_clr_num_ff(req_clr_num_ff), .mem_req_ff(mem_req_ff),
      .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .irq_ff(irq_ff), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   far_side_model far_side_model_i (.clk(clk), .reset_n(reset_n), .raise(raise), .slow(slow),
      .req_clr_ff(req_clr_ff), .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
      .mem_wdata_ff(mem_wdata_ff), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .periph_req(periph_req));
   // ==========================================
   // Tasks
   task conclude;
      begin
         $display("checks %0d mismatches %0d", check_count, fails);
         if (fails == 0 && check_count > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] v);
      reg ta, tw;
      begin
         ta = 0;
         tw = 0;
         @(posedge clk);
         awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
         while (!(ta && tw)) begin
            @(posedge clk);
            if (awready && !ta) begin ta = 1; awvalid <= 1'b0; end
            if (wready && !tw) begin tw = 1; wvalid <= 1'b0; end
         end
         while (!bvalid) @(posedge clk);
         r = bresp;
         bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge clk);
         araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
         do @(posedge clk); while (!arready);
         arvalid <= 1'b0;
         while (!rvalid) @(posedge clk);
         d = rdata;
         r = rresp;
         rready <= 1'b0;
      end
   endtask
   task rdc(input string nm, input [7:0] a, input [31:0] e);
      begin rd(a); chk(nm, e, d); end
   endtask
   // Polls busy and trap-pending so the wait ends on the unit's own completion.
   task idle;
      integer k;
      begin
         k = 0;
         d = 32'h30000;
         while (d[17:16] != 2'h0 && k < 200) begin rd(`RA_STATUS); k = k + 1; end
         chk("unit idle", 32'h0, {30'h0, d[17:16]});
      end
   endtask
   task accept(input [5:0] n);
      begin
         raise <= 1'b1;
         @(posedge clk);
         raise <= 1'b0;
         while (!req_clr_ff) @(posedge clk);
         chk("clear number", n, req_clr_num_ff);
         idle;
      end
   endtask
   // ==========================================
   // Clock, timeout and tests
   initial begin clk = 0; forever #25 clk = ~clk; end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin fails = fails + 1; conclude; end
   end
   initial begin
      reset_n = 0; raise = 0; slow = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; fails = 0; check_count = 0; cyc = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      for (s = 0; s < 11; s = s + 1) if (s != 8) rdc("reset value", s * 4, 32'h0);
      rd(8'h3C); chk("unmapped read", `RESP_SLVERR, r);
      wr(8'h3C, 32'h1); chk("unmapped write", `RESP_SLVERR, r);
      far_side_model_i.mem[0] = 32'h0000050C;
      far_side_model_i.mem[16'h4C] = 32'h5678;
      wr(`RA_VBASE, 32'h100); wr(`RA_FBASE, 32'h200); wr(`RA_ISP, 32'h400);
      wr(`RA_USP, 32'h800); wr(`RA_PC, 32'h1234); wr(`RA_IMASK, 32'h3); wr(`RA_FLAG, 32'hC4);
      accept(6'd12);
      chk("saved flags", 32'hC4, far_side_model_i.mem[16'hFF]);
      chk("saved pc", 32'h1234, far_side_model_i.mem[16'hFE]);
      rdc("pc", `RA_PC, 32'h5678);
      rdc("isp", `RA_ISP, 32'h3F8);
      rdc("flags", `RA_FLAG, 32'h0);
      rdc("level", `RA_IPL, 32'h5);
      rdc("istat", `RA_ISTAT, 32'h1);
      chk("irq set", 1, irq_ff);
      wr(`RA_IMASK, 32'h0); repeat (2) @(posedge clk); chk("irq masked", 0, irq_ff);
      wr(`RA_IMASK, 32'h3); repeat (2) @(posedge clk); chk("irq unmasked", 1, irq_ff);
      wr(`RA_ISTAT, 32'h1); repeat (2) @(posedge clk); chk("irq cleared", 0, irq_ff);
      far_side_model_i.mem[0] = 32'h0000030D;
      far_side_model_i.mem[16'h4D] = 32'h7777;
      raise <= 1'b1; @(posedge clk); raise <= 1'b0;
      repeat (40) @(posedge clk);
      chk("blocked clears", 1, far_side_model_i.clr_count);
      wr(`RA_FLAG, 32'h40);
      while (!req_clr_ff) @(posedge clk);
      chk("nested number", 13, req_clr_num_ff);
      idle;
      rdc("nested pc", `RA_PC, 32'h7777);
      chk("nested flags", 32'h40, far_side_model_i.mem[16'hFD]);
      slow <= 1'b0;
      far_side_model_i.mem[16'h72] = 32'h9ABC;
      wr(`RA_FLAG, 32'h80); wr(`RA_TRAP, 32'd50); idle;
      rdc("trap pc", `RA_PC, 32'h9ABC);
      chk("trap flags", 32'h80, far_side_model_i.mem[16'hFB]);
      chk("trap saved pc", 32'h7777, far_side_model_i.mem[16'hFA]);
      rdc("trap isp", `RA_ISP, 32'h3E8);
      rdc("trap level", `RA_IPL, 32'h3);
      chk("trap clears", 2, far_side_model_i.clr_count);
      wr(`RA_TRAP, 32'd10); idle;
      rdc("refused istat", `RA_ISTAT, 32'h3);
      rdc("refused pc", `RA_PC, 32'h9ABC);
      far_side_model_i.mem[0] = 32'h00000605;
      far_side_model_i.mem[16'h45] = 32'hAAAA;
      wr(`RA_TRAP, 32'd5); idle;
      rdc("info trap pc", `RA_PC, 32'hAAAA);
      rdc("info trap level", `RA_IPL, 32'h6);
      chk("info trap clears", 3, far_side_model_i.clr_count);
      for (s = 0; s < 9; s = s + 1) begin
         far_side_model_i.mem[16'h80 + s] = 32'hF00 + s;
         wr(`RA_TRAP, 32'h100 + s); idle;
         rdc("fixed slot pc", `RA_PC, 32'hF00 + s);
      end
      conclude;
   end
endmodule
